// ---- src/tone_link_defines.vh ----
// Constants for the tone burst bit link
`ifndef TONE_LINK_DEFINES_VH
`define TONE_LINK_DEFINES_VH
// Clock rate in kHz
`define CLK_KHZ         20000
// Carrier nominal frequency in kHz
`define TONE_KHZ        22
// Carrier tolerance in percent
`define TONE_TOL_PCT    20
// Cycles per half period of the nominal carrier (rounded down)
`define HALF_CYC        ((`CLK_KHZ) / (2 * `TONE_KHZ))
// Longest half period accepted: nominal less 20 percent
`define HALF_MAX        (((`CLK_KHZ) * 100) / (2 * `TONE_KHZ * (100 - `TONE_TOL_PCT)))
// Shortest half period accepted: nominal plus 20 percent, rounded up
`define HALF_MIN        (((`CLK_KHZ) * 100 + 2 * `TONE_KHZ * (100 + `TONE_TOL_PCT) - 1) / (2 * `TONE_KHZ * (100 + `TONE_TOL_PCT)))
// Timing unit in microseconds
`define UNIT_US         500
// Cycles per timing unit
`define UNIT_CYC        ((`CLK_KHZ) * (`UNIT_US) / 1000)
// Units per bit, units of carrier for a zero and a one
`define BIT_UNITS       2'h3
`define ZERO_UNITS      2'h2
`define ONE_UNITS       2'h1
// Carrier gone after this many cycles with no edge: two longest half periods
`define GAP_CYC         (2 * `HALF_MAX + 2)
// Burst length threshold between one and two units: 1.5 units
`define SPLIT_CYC       ((`UNIT_CYC) * 3 / 2)
// Shortest burst taken as a bit: 0.4 unit; longest: 2.6 units
`define BURST_MIN       ((`UNIT_CYC) * 2 / 5)
`define BURST_MAX       ((`UNIT_CYC) * 13 / 5)
`endif

// ---- src/tone_detect.v ----
// Carrier presence detector on the comparator output
`timescale 1ns/1ps
`include "tone_link_defines.vh"
module tone_detect (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire toneIn,
  output reg  carrierOn
);
  reg        sync1Reg;
  reg        sync2Reg;
  reg        lastReg;
  reg [9:0]  halfCntReg;
  // Must reach the gap limit, which lies above 1023 cycles
  reg [10:0] gapCntReg;
  reg [1:0]  goodReg;
  wire       edgeSeen = sync2Reg ^ lastReg;
  wire       halfOk   = (halfCntReg >= `HALF_MIN) &&
                        (halfCntReg <= `HALF_MAX);

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1Reg   <= 1'b0;
      sync2Reg   <= 1'b0;
      lastReg    <= 1'b0;
      halfCntReg <= 10'h000;
      gapCntReg  <= 11'h000;
      goodReg    <= 2'h0;
      carrierOn  <= 1'b0;
    end else begin
      sync1Reg <= toneIn;
      sync2Reg <= sync1Reg;
      lastReg  <= sync2Reg;
      if (edgeSeen) begin
        halfCntReg <= 10'h001;
        gapCntReg  <= 11'h000;
        // Glitches shorter than a legal half period count as noise
        if (halfOk) begin
          if (goodReg != 2'h3)
            goodReg <= goodReg + 2'h1;
        end else begin
          goodReg <= 2'h0;
        end
      end else begin
        if (halfCntReg != 10'h3FF)
          halfCntReg <= halfCntReg + 10'h001;
        if (gapCntReg != 11'h7FF)
          gapCntReg <= gapCntReg + 11'h001;
      end
      // Carrier within the accepted band, seen for three half periods
      if (gapCntReg >= `GAP_CYC) begin
        carrierOn <= 1'b0;
        goodReg   <= 2'h0;
      end else if (goodReg == 2'h3) begin
        carrierOn <= 1'b1;
      end
    end
  end
endmodule

// ---- src/tone_burst_bit_link.v ----
// Pulse width keyed tone encoder and decoder
`timescale 1ns/1ps
`include "tone_link_defines.vh"
// Function
// - Line is either full carrier or silence, nothing in between.
// - Carrier 22 kHz nominal; receiver accepts plus or minus twenty percent.
// - Bit is three 0.5 ms units: zero 2 on 1 off, one 1 on 2 off.
// - Every unit monitors the line, including its own bursts.
// - Detector ignores small noise tones; only clean carrier counts.
module tone_burst_bit_link (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire txValid,
  input  wire txBit,
  input  wire toneIn,
  output reg  txReady,
  output reg  toneOut,
  output reg  toneEnable,
  output reg  rxValid,
  output reg  rxBit,
  output reg  rxError,
  output reg  lineActive
);
  // ----------------------------------------------------------------
  // Transmit states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_BURST = 3'b010;
  localparam [2:0] S_PAUSE = 3'b100;

  reg [2:0]  stateReg;
  reg [2:0]  stateNext;
  reg [14:0] unitCntReg;
  reg [1:0]  unitsReg;
  reg [1:0]  burstUnitsReg;
  reg [9:0]  halfCntReg;
  reg        phaseReg;
  reg [15:0] burstLenReg;
  reg        lastOnReg;
  wire       carrierOn;
  wire       unitEnd;
  wire       burstDone;
  wire       bitDone;
  wire       halfEnd;
  wire       takeBit;
  wire       burstEnded;
  wire       lenBad;
  wire       burstNext;

  // ----------------------------------------------------------------
  // Transmit timing decodes
  // ----------------------------------------------------------------
  assign unitEnd   = (unitCntReg == `UNIT_CYC - 1);
  assign burstDone = unitEnd && (unitsReg == burstUnitsReg - 2'h1);
  assign bitDone   = unitEnd && (unitsReg == `BIT_UNITS - 2'h1);
  assign halfEnd   = (halfCntReg == `HALF_CYC - 1);
  // Bit taken at the start of its burst; back to back bits allowed
  // A new bit waits for the full pause, so bit period never shrinks
  assign takeBit   = (stateReg == S_IDLE && txValid) ||
                     (stateReg == S_PAUSE && bitDone && txValid);
  assign burstNext = (stateNext == S_BURST);

  // ----------------------------------------------------------------
  // Transmit state machine
  // ----------------------------------------------------------------
  always @* begin
    stateNext = stateReg;
    case (stateReg)
      S_IDLE: begin
        if (txValid)
          stateNext = S_BURST;
      end
      S_BURST: begin
        if (burstDone)
          stateNext = S_PAUSE;
      end
      S_PAUSE: begin
        if (bitDone)
          stateNext = txValid ? S_BURST : S_IDLE;
      end
      default: begin
        stateNext = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      stateReg <= S_IDLE;
    else
      stateReg <= stateNext;
  end

  // ----------------------------------------------------------------
  // Bit length latch and unit counter
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      burstUnitsReg <= `ONE_UNITS;
    end else if (takeBit) begin
      burstUnitsReg <= txBit ? `ONE_UNITS : `ZERO_UNITS;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unitCntReg <= 15'h0000;
      unitsReg   <= 2'h0;
    end else if (takeBit) begin
      unitCntReg <= 15'h0000;
      unitsReg   <= 2'h0;
    end else if (stateReg != S_IDLE) begin
      if (unitEnd) begin
        unitCntReg <= 15'h0000;
        unitsReg   <= unitsReg + 2'h1;
      end else begin
        unitCntReg <= unitCntReg + 15'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit handshake
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      txReady <= 1'b0;
    else
      txReady <= takeBit;
  end

  // ----------------------------------------------------------------
  // Carrier generator
  // ----------------------------------------------------------------
  // Phase restarts with each bit so every burst opens on a high half
  // Counter runs on through the pause; output is gated off there
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      halfCntReg <= 10'h000;
      phaseReg   <= 1'b0;
    end else if (takeBit) begin
      halfCntReg <= 10'h000;
      phaseReg   <= 1'b0;
    end else if (stateReg != S_IDLE) begin
      if (halfEnd) begin
        halfCntReg <= 10'h000;
        phaseReg   <= ~phaseReg;
      end else begin
        halfCntReg <= halfCntReg + 10'h001;
      end
    end
  end

  // Full shunt drive or none; no partial level exists
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      toneEnable <= 1'b0;
      toneOut    <= 1'b0;
    end else begin
      toneEnable <= burstNext;
      toneOut    <= burstNext & (takeBit | ~phaseReg);
    end
  end

  // ----------------------------------------------------------------
  // Receive: own bursts are decoded too, as the line is shared
  // ----------------------------------------------------------------
  tone_detect detector (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .toneIn    (toneIn),
    .carrierOn (carrierOn)
  );

  assign burstEnded = lastOnReg & ~carrierOn;
  assign lenBad     = (burstLenReg < `BURST_MIN) ||
                      (burstLenReg > `BURST_MAX);

  // ----------------------------------------------------------------
  // Burst length
  // ----------------------------------------------------------------
  // Length in clock cycles, held until the burst is judged
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      burstLenReg <= 16'h0000;
      lastOnReg   <= 1'b0;
    end else begin
      lastOnReg <= carrierOn;
      if (carrierOn) begin
        if (burstLenReg != 16'hFFFF)
          burstLenReg <= burstLenReg + 16'h0001;
      end else if (lastOnReg) begin
        burstLenReg <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit decision
  // ----------------------------------------------------------------
  // Midpoint threshold absorbs detector stretch and skew
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxValid <= 1'b0;
      rxError <= 1'b0;
      rxBit   <= 1'b0;
    end else begin
      rxValid <= burstEnded & ~lenBad;
      rxError <= burstEnded & lenBad;
      if (burstEnded && !lenBad)
        rxBit <= (burstLenReg < `SPLIT_CYC);
    end
  end

  // ----------------------------------------------------------------
  // Line activity
  // ----------------------------------------------------------------
  // Busy flag follows the detector one cycle late
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      lineActive <= 1'b0;
    else
      lineActive <= carrierOn;
  end
endmodule

// ---- test/outdoor_unit_model.sv ----
// Outdoor unit model on the tone line
`timescale 1ns/1ps
module outdoor_unit_model (
  input  wire  clk_sys,
  input  wire  loopOn,
  input  wire  toneOut,
  input  wire  toneEnable,
  output logic toneIn
);
  logic ownTone = 1'b0;
  // Shared line, so our own bursts come back too
  assign toneIn = ownTone | (loopOn & toneEnable & toneOut);
  // Carrier fully on for len cycles, then silence
  task automatic send_burst(input int len, input int half);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys);
      #1 ownTone = ((i / half) % 2) == 0;
    end
    @(posedge clk_sys);
    #1 ownTone = 1'b0;
  endtask
endmodule

// ---- test/tone_burst_bit_link_assertions.sv ----
// Checker for the tone burst bit link
`timescale 1ns/1ps
module tone_burst_bit_link_assertions (
  input wire clk_sys,
  input wire rst_b,
  input wire toneOut,
  input wire toneEnable,
  input wire txReady,
  input wire rxValid,
  input wire rxError
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  int onLen;
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b) onLen <= 0;
    else onLen <= toneEnable ? onLen + 1 : 0;
  sequence burstEnd; $fell(toneEnable); endsequence
  a_idle_tone_low: assert property (!toneEnable |-> !toneOut)
    else $error("carrier outside burst");
  a_burst_len: assert property (burstEnd |-> onLen inside {10000, 20000})
    else $error("burst length wrong");
  a_ready_starts: assert property (txReady |-> $rose(toneEnable))
    else $error("burst not started with ready");
  a_ready_once: assert property (txReady |=> !txReady)
    else $error("ready longer than a cycle");
  a_rx_once: assert property (rxValid |=> !rxValid)
    else $error("rx valid longer than a cycle");
  a_rx_exclusive: assert property (!(rxValid && rxError))
    else $error("valid and error together");
endmodule
bind tone_burst_bit_link tone_burst_bit_link_assertions chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .toneOut(toneOut),
  .toneEnable(toneEnable), .txReady(txReady), .rxValid(rxValid),
  .rxError(rxError));

// ---- test/tone_burst_bit_link_test.sv ----
// Self-checking bench for the tone burst bit link
`timescale 1ns/1ps
module tone_burst_bit_link_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic txValid = 1'b0;
  logic txBit = 1'b0;
  logic loopOn = 1'b0;
  wire  toneIn, txReady, toneOut, toneEnable;
  wire  rxValid, rxBit, rxError, lineActive;
  int   fails = 0;
  int   cmp_count = 0;
  int   rxSeen = 0;
  always #25 clk_sys = ~clk_sys;
  // Every decoded or rejected burst, counted off the launching edge
  always @(negedge clk_sys)
    if (rxValid === 1'b1 || rxError === 1'b1) rxSeen++;
  tone_burst_bit_link dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .txValid(txValid), .txBit(txBit), .toneIn(toneIn), .txReady(txReady),
    .toneOut(toneOut), .toneEnable(toneEnable), .rxValid(rxValid),
    .rxBit(rxBit), .rxError(rxError), .lineActive(lineActive));
  outdoor_unit_model model_u (.clk_sys(clk_sys), .loopOn(loopOn),
    .toneOut(toneOut), .toneEnable(toneEnable), .toneIn(toneIn));
  task automatic chk(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (txReady !== 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("txReady", 1'b1, txReady);
  endtask
  // Pulses last one cycle, so sample just after each edge
  task automatic wait_rx(input logic expBit, input logic expErr);
    int n;
    n = 0;
    while (rxValid !== 1'b1 && rxError !== 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("rxValid", !expErr, rxValid);
    chk("rxError", expErr, rxError);
    chk("lineActive", 1'b0, lineActive);
    if (!expErr) chk("rxBit", expBit, rxBit);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_send_loop();
    loopOn = 1'b1;
    txValid = 1'b1;
    txBit = 1'b1;
    wait_ready();
    txBit = 1'b0;
    repeat (3000) @(posedge clk_sys);
    #1 chk("lineActive", 1'b1, lineActive);
    wait_rx(1'b1, 1'b0);
    wait_ready();
    txValid = 1'b0;
    wait_rx(1'b0, 1'b0);
    loopOn = 1'b0;
  endtask
  // Carrier near both ends of the accepted band, then a nominal burst too short to be a bit
  task automatic t_recv_skew();
    model_u.send_burst(20000, 520);
    wait_rx(1'b0, 1'b0);
    model_u.send_burst(10000, 400);
    wait_rx(1'b1, 1'b0);
    model_u.send_burst(3000, 454);
    wait_rx(1'b0, 1'b1);
  endtask
  // Out of band or glitchy carrier must yield no burst at all
  task automatic t_noise();
    int seen;
    seen = rxSeen;
    model_u.send_burst(2500, 600);
    repeat (1300) @(posedge clk_sys);
    #1 chk("rxQuiet", 1'b1, rxSeen == seen);
    model_u.send_burst(1500, 200);
    repeat (1300) @(posedge clk_sys);
    #1 chk("rxQuiet", 1'b1, rxSeen == seen);
    chk("lineActive", 1'b0, lineActive);
  endtask
  task automatic close_out();
    $display("fails %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    @(posedge clk_sys);
    #1 chk("toneOut", 1'b0, toneOut);
    t_send_loop();
    t_recv_skew();
    t_noise();
    close_out();
  end
  initial begin
    #(98000 * 50);
    fails++;
    close_out();
  end
endmodule
